/* hw/ppbt_pkg.sv */
/*
 * Constants, field layout and carrier types for the port PWM / blink timing core.
 * Assumes a single 50 MHz system clock; the ring oscillator is modelled as a
 * divided tick of that clock and the serial bus engine lives outside.
 */
package ppbt_pkg;

	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned OSC_HZ       = 32_768;
	localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
	localparam int unsigned OSC_DIV_W    = 10;

	localparam logic [7:0] ADDR_PORT_FIRST = 8'h01;
	localparam logic [7:0] ADDR_PORT_LAST  = 8'h04;
	localparam logic [7:0] ADDR_CFG_A      = 8'h26;
	localparam logic [7:0] ADDR_CFG_B      = 8'h27;

	localparam int unsigned CFGA_RST_PORTS  = 0;
	localparam int unsigned CFGA_RST_TIMERS = 1;
	localparam int unsigned CFGA_BLINK_LSB  = 2;
	localparam int unsigned CFGB_INT_OUT    = 0;
	localparam int unsigned CFGB_EXT_CLK    = 2;
	localparam int unsigned CFGB_CLK_OUT    = 3;
	localparam int unsigned CFGB_TMO_DIS    = 7;

	localparam int unsigned PORT_DIR_IN   = 7;
	localparam int unsigned PORT_PUSHPULL = 6;
	localparam int unsigned PORT_BLINK    = 5;
	localparam int unsigned PORT_INT_EN   = 5;
	localparam int unsigned PORT_DEBOUNCE = 2;

	localparam logic [7:0] PORT_RESET  = 8'h80;
	localparam logic [7:0] CFG_A_RESET = 8'h00;
	localparam logic [7:0] CFG_B_RESET = 8'h00;

	localparam int unsigned TIMER_W        = 18;
	localparam int unsigned PWM_STEP_LSB   = 5;
	localparam logic [4:0]  STAGGER_STEP   = 5'h04;
	localparam logic [2:0]  BLINK_FAST     = 3'h7;
	localparam int unsigned BLINK_FAST_TOP = 10;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} ppbt_reg_req_t;

	typedef struct packed {
		logic meta;
		logic sync;
	} ppbt_sync_t;

	typedef struct packed {
		logic pinOut;
		logic pinOe;
	} ppbt_drive_t;

	typedef struct packed {
		logic [3:0][7:0]         portReg;
		logic [7:0]              cfgA;
		logic [7:0]              cfgB;
		logic [TIMER_W-1:0]      timer;
		logic [OSC_DIV_W-1:0]    oscDiv;
		logic                    oscLevel;
		logic                    oscTick;
		logic                    extPrev;
		logic                    intPending;
		logic [3:0]              pinOut;
		logic [3:0]              pinOe;
		logic [7:0]              rdData;
	} ppbt_state_t;

endpackage : ppbt_pkg

/* hw/ppbt_sync.sv */
/*
 * Two-stage level synchroniser with constant reset value.
 * Assumes the input is a level that may change at any time.
 */
`timescale 1ns/100ps
`default_nettype none
module ppbt_sync
	import ppbt_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic ce,
	input  wire logic levelIn,
	output logic      levelOut
);

	ppbt_sync_t state_r;
	ppbt_sync_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (ce) begin
			state_nxt.meta = levelIn;
			state_nxt.sync = state_r.meta;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= '{meta: RESET_VAL, sync: RESET_VAL};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign levelOut = state_r.sync;

endmodule : ppbt_sync
`default_nettype wire

/* hw/ppbt_port_drive.sv */
/*
 * Per-port waveform decode: PWM, blink, static levels and drive type.
 * Assumes the PWM step already carries this port's phase offset.
 */
`timescale 1ns/100ps
`default_nettype none
module ppbt_port_drive
	import ppbt_pkg::*;
(
	input  wire logic [7:0] portReg,
	input  wire logic [4:0] pwmStep,
	input  wire logic [3:0] blinkPhase,
	input  wire logic       openDrainOnly,
	output ppbt_drive_t     drive
);

	logic level;

	always_comb begin
		level = 1'b0;
		if (portReg[7:4] == 4'h7) begin
			level = 1'b1;
		end else if (portReg[PORT_BLINK]) begin
			level = blinkPhase < portReg[3:0];
		end else begin
			level = pwmStep < portReg[4:0];
		end
	end

	always_comb begin
		drive = '{pinOut: 1'b0, pinOe: 1'b0};
		if (!portReg[PORT_DIR_IN]) begin
			if (portReg[PORT_PUSHPULL] && !openDrainOnly) begin
				drive = '{pinOut: level, pinOe: 1'b1};
			end else begin
				drive = '{pinOut: 1'b0, pinOe: !level};
			end
		end
	end

endmodule : ppbt_port_drive
`default_nettype wire

/* hw/ppbt_core.sv */
/*
 * Timing and control core of a four-port expander: clock selection,
 * clock output, staggered 32-step PWM, global blink, reset pin handling
 * and the latched interrupt on port one.
 * Assumes an outside serial engine presents decoded register accesses on
 * regReq and sees input transitions already detected on transEvent.
 */
`timescale 1ns/100ps
`default_nettype none
module ppbt_core
	import ppbt_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire logic          ce,
	input  wire ppbt_reg_req_t regReq,
	output logic [7:0]         regRdData,
	input  wire logic          rstPin_n,
	input  wire logic [3:0]    portIn,
	input  wire logic [3:0]    transEvent,
	output logic [3:0]         portOut,
	output logic [3:0]         portOe,
	output logic               busIdleHold,
	output logic               intPending,
	output logic               oscRun,
	output logic               oscTick,
	output logic               timingTick,
	output logic               timeoutEn
);

	ppbt_state_t  state_r;
	ppbt_state_t  state_nxt;
	logic         rstPinSync;
	logic         extClkIn;
	logic         extSel;
	logic         clkOutEn;
	logic         intOutEn;
	logic         extRise;
	logic         anyTimed;
	logic         debounceEn;
	logic         selLevel;
	logic [4:0]   baseStep;
	logic [3:0]   blinkPh;
	logic [3:0]   isInput;
	logic         accessOk;
	logic         portRead;
	logic         intSet;
	ppbt_drive_t  drv [4];
	logic [4:0]   stepOf [4];

	function automatic logic addrIsPort(input logic [7:0] a);
		return (a >= ADDR_PORT_FIRST) && (a <= ADDR_PORT_LAST);
	endfunction : addrIsPort

	function automatic logic [1:0] portIndex(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_PORT_FIRST;
		return d[1:0];
	endfunction : portIndex

	// Blink position in sixteenths of the selected period
	function automatic logic [3:0] blinkPhaseOf(
		input logic [TIMER_W-1:0] t,
		input logic [2:0]         code
	);
		int unsigned top;
		top = (code == BLINK_FAST) ? BLINK_FAST_TOP : TIMER_W - int'(code);
		return 4'(t >> (top - 4));
	endfunction : blinkPhaseOf

	// Chip-enable and bus hold follow the synchronised reset pin
	ppbt_sync #(
		.RESET_VAL (1'b0)
	) u_rst_sync (
		.clock    (clock),
		.nrst     (nrst),
		.ce       (ce),
		.levelIn  (rstPin_n),
		.levelOut (rstPinSync)
	);

	assign extSel     = state_r.cfgB[CFGB_EXT_CLK];
	assign clkOutEn   = state_r.cfgB[CFGB_CLK_OUT];
	assign intOutEn   = state_r.cfgB[CFGB_INT_OUT];
	assign timeoutEn  = !state_r.cfgB[CFGB_TMO_DIS];
	assign extClkIn   = extSel ? portIn[1] : 1'b0;
	assign extRise    = extClkIn && !state_r.extPrev;

	always_comb begin
		anyTimed   = 1'b0;
		debounceEn = 1'b0;
		for (int i = 0; i < 4; i++) begin
			isInput[i] = state_r.portReg[i][PORT_DIR_IN];
			if (!isInput[i] && state_r.portReg[i][4:0] != 5'h00) begin
				anyTimed = 1'b1;
			end
			if (isInput[i] && state_r.portReg[i][PORT_DEBOUNCE]) begin
				debounceEn = 1'b1;
			end
		end
	end

	// Oscillator runs for debounce, timeout, and on the internal clock for clock out or outputs with nonzero bits 4:0
	assign oscRun = (anyTimed && !extSel) || debounceEn || timeoutEn
		|| (clkOutEn && !extSel);

	// Timing tick: internal oscillator or external clock edges
	assign timingTick = extSel ? extRise : state_r.oscTick;
	assign selLevel   = extSel ? extClkIn : state_r.oscLevel;

	// Timeout and debounce stay on the internal tick
	assign oscTick = state_r.oscTick;

	// PWM step is timer divided by 32 ticks per PWM clock
	assign baseStep = state_r.timer[PWM_STEP_LSB +: 5];
	assign blinkPh  = blinkPhaseOf(state_r.timer,
		state_r.cfgA[CFGA_BLINK_LSB +: 3]);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_port
			// Each port shifted by one eighth of the PWM period
			assign stepOf[g] = baseStep + 5'(STAGGER_STEP * g);

			ppbt_port_drive u_drive (
				.portReg       (state_r.portReg[g]),
				.pwmStep       (stepOf[g]),
				.blinkPhase    (blinkPh),
				.openDrainOnly (g == 0),
				.drive         (drv[g])
			);
		end
	endgenerate

	assign accessOk = rstPinSync;
	assign portRead = accessOk && regReq.rd && addrIsPort(regReq.addr);
	assign intSet   = |(transEvent & isInput
		& {state_r.portReg[3][PORT_INT_EN], state_r.portReg[2][PORT_INT_EN],
		   state_r.portReg[1][PORT_INT_EN], state_r.portReg[0][PORT_INT_EN]});

	always_comb begin
		state_nxt = state_r;
		state_nxt.oscTick = 1'b0;
		if (ce) begin
			state_nxt.extPrev = extClkIn;

			// Ring oscillator model, stopped and cleared when idle
			if (!oscRun) begin
				state_nxt.oscDiv   = '0;
				state_nxt.oscLevel = 1'b0;
			end else if (state_r.oscDiv == OSC_DIV_W'(OSC_HALF_CYC - 1)) begin
				state_nxt.oscDiv   = '0;
				state_nxt.oscLevel = !state_r.oscLevel;
				state_nxt.oscTick  = !state_r.oscLevel;
			end else begin
				state_nxt.oscDiv = state_r.oscDiv + 1'b1;
			end

			// Shared PWM and blink time base
			if (!rstPinSync && state_r.cfgA[CFGA_RST_TIMERS]) begin
				state_nxt.timer = '0;
			end else if (timingTick) begin
				state_nxt.timer = state_r.timer + 1'b1;
			end

			// Register writes only while enabled
			if (accessOk && regReq.wr) begin
				if (addrIsPort(regReq.addr)) begin
					state_nxt.portReg[portIndex(regReq.addr)] = regReq.data;
				end else if (regReq.addr == ADDR_CFG_A) begin
					state_nxt.cfgA = regReq.data;
				end else if (regReq.addr == ADDR_CFG_B) begin
					state_nxt.cfgB = regReq.data;
				end
			end

			// Reset pin may restore port defaults
			if (!rstPinSync && state_r.cfgA[CFGA_RST_PORTS]) begin
				for (int i = 0; i < 4; i++) begin
					state_nxt.portReg[i] = PORT_RESET;
				end
			end

			// Read data, zero when disabled or unmapped
			state_nxt.rdData = 8'h00;
			if (accessOk && regReq.rd) begin
				if (addrIsPort(regReq.addr)) begin
					state_nxt.rdData = state_r.portReg[portIndex(regReq.addr)];
				end else if (regReq.addr == ADDR_CFG_A) begin
					state_nxt.rdData = state_r.cfgA;
				end else if (regReq.addr == ADDR_CFG_B) begin
					state_nxt.rdData = state_r.cfgB;
				end
			end

			// Latched interrupt: new event beats the clearing read
			if (intOutEn && intSet) begin
				state_nxt.intPending = 1'b1;
			end else if (portRead) begin
				state_nxt.intPending = 1'b0;
			end
			// Reset pin deliberately not part of the clear term

			// Registered pin drive with function overrides
			for (int i = 0; i < 4; i++) begin
				state_nxt.pinOut[i] = drv[i].pinOut;
				state_nxt.pinOe[i]  = drv[i].pinOe;
			end
			if (intOutEn) begin
				state_nxt.pinOut[0] = 1'b0;
				state_nxt.pinOe[0]  = state_nxt.intPending;
			end
			if (extSel) begin
				state_nxt.pinOut[1] = 1'b0;
				state_nxt.pinOe[1]  = 1'b0;
			end
			if (clkOutEn) begin
				state_nxt.pinOut[2] = selLevel;
				state_nxt.pinOe[2]  = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r.portReg    <= {4{PORT_RESET}};
			state_r.cfgA       <= CFG_A_RESET;
			state_r.cfgB       <= CFG_B_RESET;
			state_r.timer      <= '0;
			state_r.oscDiv     <= '0;
			state_r.oscLevel   <= 1'b0;
			state_r.oscTick    <= 1'b0;
			state_r.extPrev    <= 1'b0;
			state_r.intPending <= 1'b0;
			state_r.pinOut     <= 4'h0;
			state_r.pinOe      <= 4'h0;
			state_r.rdData     <= 8'h00;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign regRdData   = state_r.rdData;
	assign portOut     = state_r.pinOut;
	assign portOe      = state_r.pinOe;
	assign intPending  = state_r.intPending;
	assign busIdleHold = !rstPinSync;

endmodule : ppbt_core
`default_nettype wire

/* dv/ppbt_core_assertions.sv */
/*
 * Concurrent checks on the timing core ports: reset pin handling,
 * latched interrupt, oscillator tick and pin drive relations.
 * Assumes one clock domain and is bound onto every core instance.
 */
`timescale 1ns/100ps
`default_nettype none
module ppbt_core_chk
	import ppbt_pkg::*;
(
	input wire logic          clock,
	input wire logic          nrst,
	input wire logic          ce,
	input wire ppbt_reg_req_t regReq,
	input wire logic [7:0]    regRdData,
	input wire logic          rstPin_n,
	input wire logic [3:0]    transEvent,
	input wire logic [3:0]    portOut,
	input wire logic [3:0]    portOe,
	input wire logic          busIdleHold,
	input wire logic          intPending,
	input wire logic          oscRun,
	input wire logic          oscTick,
	input wire logic          timingTick
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_idle_hold: assert property ((ce && !rstPin_n) [*3] |-> busIdleHold)
		else $error("bus not held idle");
	a_idle_free: assert property ((ce && rstPin_n) [*3] |-> !busIdleHold)
		else $error("bus held idle while enabled");
	a_rd_refused: assert property (ce && regReq.rd && busIdleHold |=> regRdData == 8'h00)
		else $error("read answered while disabled");
	a_int_cause: assert property ($rose(intPending) |-> $past(transEvent) != 4'h0)
		else $error("interrupt set without event");
	a_int_drive: assert property ($rose(intPending) |-> portOe[0] && !portOut[0])
		else $error("interrupt pin not pulled low");
	a_int_clear: assert property ($fell(intPending) |-> $past(regReq.rd) && !$past(busIdleHold)
		&& $past(regReq.addr) inside {[8'h01:8'h04]})
		else $error("interrupt cleared without port read");
	a_int_keep: assert property (intPending && !rstPin_n && !regReq.rd |=> intPending)
		else $error("reset pin cleared interrupt");
	a_osc_need: assert property (oscTick |-> $past(oscRun))
		else $error("oscillator tick while stopped");
	a_osc_pulse: assert property (oscTick |=> !oscTick [*8])
		else $error("oscillator tick too close");
	a_drain_only: assert property (portOe[0] |-> !portOut[0])
		else $error("port one driven high");
	a_tick_pulse: assert property (timingTick |=> !timingTick)
		else $error("timing tick wider than one cycle");
endmodule : ppbt_core_chk

bind ppbt_core ppbt_core_chk u_chk (.clock, .nrst, .ce, .regReq, .regRdData, .rstPin_n,
	.transEvent, .portOut, .portOe, .busIdleHold, .intPending, .oscRun, .oscTick, .timingTick);
`default_nettype wire

/* dv/ppbt_far_side.sv */
/*
 * Far side of the port pins: pull-ups on every pin and a 1 MHz
 * external timing clock on port two that stands still unless run.
 * Assumes the same 50 MHz system clock as the core.
 */
`timescale 1ns/100ps
`default_nettype none
module ppbt_far_side
	import ppbt_pkg::*;
#(
	parameter int HALF = 25
) (
	input  wire logic       clock,
	input  wire logic       run,
	input  wire logic [3:0] portOut,
	input  wire logic [3:0] portOe,
	output logic      [3:0] portIn
);
	int   cnt    = 0;
	logic extClk = 1'b0;

	always @(posedge clock) begin
		if (!run) begin
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			cnt    <= 0;
			extClk <= !extClk;
		end else begin
			cnt <= cnt + 1;
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			portIn[i] = portOe[i] ? portOut[i] : 1'b1;
		end
		if (run) begin
			portIn[1] = extClk;
		end
	end
endmodule : ppbt_far_side
`default_nettype wire

/* dv/tb_top.sv */
/*
 * Self-checking bench for the timing core: register access, reset pin,
 * interrupt, static levels, PWM and blink duty, clock output.
 * Assumes the far-side model supplies pins and the external clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import ppbt_pkg::*;
;
	logic          clock;
	logic          nrst       = 1'b0;
	logic          ce         = 1'b1;
	logic          rstPin_n   = 1'b1;
	logic          run        = 1'b0;
	ppbt_reg_req_t regReq     = '0;
	logic [3:0]    transEvent = 4'h0;
	logic [3:0]    portIn, portOut, portOe;
	logic [7:0]    regRdData;
	logic          busIdleHold, intPending, oscRun, oscTick, timingTick, timeoutEn;
	int            failures   = 0;
	int            compares   = 0;
	int            cycles     = 0;
	int            n2, n3, nOsc, nCyc;
	logic          prv;
	logic [7:0]    rA [7]     = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h26, 8'h27, 8'h10};
	logic [7:0]    rE [7]     = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};

	ppbt_core u_dut (.clock, .nrst, .ce, .regReq, .regRdData, .rstPin_n, .portIn,
		.transEvent, .portOut, .portOe, .busIdleHold, .intPending, .oscRun, .oscTick,
		.timingTick, .timeoutEn);
	ppbt_far_side u_far (.clock, .run, .portOut, .portOe, .portIn);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clock);
		regReq = '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clock);
		regReq = '0;
		chk("regRdData", e, regRdData);
	endtask : rd

	// Samples pins once per timing tick over n ticks
	task automatic tick_count(input int n);
		n2 = 0;
		n3 = 0;
		nOsc = 0;
		nCyc = 0;
		for (int t = 0; t < n; ) begin
			@(negedge clock);
			nCyc++;
			nOsc += oscTick;
			if (timingTick === 1'b1) begin
				t++;
				n2 += (portOut[2] === 1'b1);
				n3 += (portOut[3] === 1'b1);
			end
		end
	endtask : tick_count

	initial begin
		cyc(16);
		nrst = 1'b1;
		cyc(3);
		for (int i = 0; i < 7; i++) begin
			rd(rA[i], rE[i]);
		end
		wr(8'h27, 8'h80);
		cyc(2);
		chk("oscRun", 1'b0, oscRun);
		chk("timeoutEn", 1'b0, timeoutEn);
		wr(8'h27, 8'h00);
		cyc(2);
		chk("oscRun", 1'b1, oscRun);
		chk("timeoutEn", 1'b1, timeoutEn);
		wr(8'h04, 8'h7F);
		cyc(3);
		chk("drive3", 2'b11, {portOut[3], portOe[3]});
		wr(8'h04, 8'h40);
		cyc(3);
		chk("drive3", 2'b01, {portOut[3], portOe[3]});
		// Disabled device ignores the bus
		rstPin_n = 1'b0;
		cyc(3);
		chk("busIdleHold", 1'b1, busIdleHold);
		wr(8'h04, 8'h55);
		rd(8'h04, 8'h00);
		rstPin_n = 1'b1;
		cyc(3);
		rd(8'h04, 8'h40);
		// Clock enable low freezes state and ignores the bus
		cyc(1);
		ce = 1'b0;
		wr(8'h04, 8'h7F);
		rd(8'h04, 8'h00);
		ce = 1'b1;
		rd(8'h04, 8'h40);
		wr(8'h26, 8'h01);
		rstPin_n = 1'b0;
		cyc(4);
		rstPin_n = 1'b1;
		cyc(3);
		rd(8'h04, 8'h80);
		wr(8'h27, 8'h01);
		wr(8'h03, 8'hA0);
		transEvent = 4'h4;
		@(negedge clock);
		transEvent = 4'h0;
		chk("intDrive", 3'b101, {intPending, portOut[0], portOe[0]});
		rstPin_n = 1'b0;
		cyc(5);
		rstPin_n = 1'b1;
		cyc(3);
		chk("intPending", 1'b1, intPending);
		rd(8'h10, 8'h00);
		chk("intPending", 1'b1, intPending);
		rd(8'h02, 8'h80);
		chk("intPending", 1'b0, intPending);
		// Event and clearing read on one edge: the event wins
		wr(8'h03, 8'hA0);
		@(negedge clock);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: 8'h01, data: 8'h00};
		transEvent = 4'h4;
		@(negedge clock);
		regReq = '0;
		transEvent = 4'h0;
		chk("intPending", 1'b1, intPending);
		rd(8'h01, 8'h80);
		chk("intPending", 1'b0, intPending);
		// Clock source first, then the timed outputs
		wr(8'h26, 8'h1E);
		wr(8'h27, 8'h04);
		run = 1'b1;
		wr(8'h03, 8'h63);
		wr(8'h04, 8'h47);
		cyc(100);
		tick_count(1024);
		chk("blinkOn", 3 * 64, n2);
		chk("pwmOn", 7 * 32, n3);
		nCyc = nCyc / (2 * OSC_HALF_CYC);
		chk("oscTicks", 1'b1, nOsc >= nCyc && nOsc <= nCyc + 1);
		// Reset pin clears the time base; release just after a tick
		rstPin_n = 1'b0;
		cyc(200);
		chk("heldOut", 2'h1, portOut[3:2]);
		do @(negedge clock); while (timingTick !== 1'b1);
		rstPin_n = 1'b1;
		tick_count(256);
		chk("blinkRestart", 192, n2);
		chk("pwmStagger", 0, n3);
		wr(8'h27, 8'h0C);
		cyc(10);
		n2 = 0;
		prv = portOut[2];
		for (int c = 0; c < 500; c++) begin
			@(negedge clock);
			n2 += (portOut[2] === 1'b1 && prv === 1'b0);
			prv = portOut[2];
		end
		chk("clkOutEdges", 1'b1, n2 >= 9 && n2 <= 11 && portOe[2] === 1'b1);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
